// ### common/fse_pkg.sv
/*
  Types of the fault status edge filter.
  Assumes fse_regs.svh is on the include path.
*/
`include "fse_regs.svh"

package fse_pkg;

  typedef logic [`FSE_WORD_W-1:0] fse_word_t;

  typedef struct packed {
    logic inhibit;
    logic output_volt_fault;
    logic line_input_fault;
    logic overcurrent_fault;
    logic fan_fault;
    logic output_short_fault;
    logic overtemp_fault;
    logic overpower_fault;
    logic inverter_module_fault;
    logic acdc_module_fault;
  } fse_flags_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`FSE_SEL_W-1:0] sel;
    fse_word_t wdata;
  } fse_req_s;

  typedef struct packed {
    fse_word_t cond;
    fse_word_t cond_prev;
    logic primed;
    fse_word_t fall_mask;
    fse_word_t rise_mask;
    fse_word_t event_word;
    fse_word_t rdata;
    logic rvalid;
    logic summary;
  } fse_state_s;

endpackage : fse_pkg

// ### common/fse_regs.svh
/*
  Register selectors, bit positions and reset values of the fault status edge filter.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef FSE_REGS_SVH
`define FSE_REGS_SVH

`define FSE_WORD_W 16
`define FSE_SEL_W 2
`define FSE_SEL_COND 2'h0
`define FSE_SEL_FALL 2'h1
`define FSE_SEL_RISE 2'h2
`define FSE_SEL_EVENT 2'h3
`define FSE_BIT_ACDC_MOD 0
`define FSE_BIT_INVERTER_MOD 1
`define FSE_BIT_OVERPOWER 2
`define FSE_BIT_OVERTEMP 3
`define FSE_BIT_OUT_SHORT 4
`define FSE_BIT_FAN 5
`define FSE_BIT_OVERCURRENT 6
`define FSE_BIT_LINE_INPUT 7
`define FSE_BIT_OUT_VOLT 8
`define FSE_BIT_INHIBIT 9
`define FSE_USED_MASK 16'h03ff
`define FSE_MASK_RST 16'h0000

`endif

// ### core/fse_status_filter.sv
/*
  Fault status edge filter: condition word, edge masks, event word, summary bit.
  Assumes synchronous fault flags and a one-cycle read/write command port.
*/
`timescale 1ns/1ps
`include "fse_regs.svh"

module fse_status_filter (
  input wire logic i_clock, // 125 MHz clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire fse_pkg::fse_flags_s i_flags, // Live protection flags
  input wire fse_pkg::fse_req_s i_req, // Register command
  input wire logic i_summary_en, // Questionable summary enable
  output logic [`FSE_WORD_W-1:0] o_rdata, // Read data
  output logic o_rvalid, // Read data valid pulse
  output logic [`FSE_WORD_W-1:0] o_cond, // Condition word
  output logic [`FSE_WORD_W-1:0] o_event, // Event word
  output logic o_fault_summary_bit // Summary bit of status byte
);
  import fse_pkg::*;

  fse_state_s state_ff;
  fse_state_s nxt_state;
  fse_word_t live_word;
  fse_word_t fell;
  fse_word_t rose;
  fse_word_t passed;

  always_comb begin
    live_word = '0;
    live_word[`FSE_BIT_ACDC_MOD] = i_flags.acdc_module_fault;
    live_word[`FSE_BIT_INVERTER_MOD] = i_flags.inverter_module_fault;
    live_word[`FSE_BIT_OVERPOWER] = i_flags.overpower_fault;
    live_word[`FSE_BIT_OVERTEMP] = i_flags.overtemp_fault;
    live_word[`FSE_BIT_OUT_SHORT] = i_flags.output_short_fault;
    live_word[`FSE_BIT_FAN] = i_flags.fan_fault;
    live_word[`FSE_BIT_OVERCURRENT] = i_flags.overcurrent_fault;
    live_word[`FSE_BIT_LINE_INPUT] = i_flags.line_input_fault;
    live_word[`FSE_BIT_OUT_VOLT] = i_flags.output_volt_fault;
    live_word[`FSE_BIT_INHIBIT] = i_flags.inhibit;
  end

  // Edges of the registered condition word against its previous value
  genvar g;
  for (g = 0; g < `FSE_WORD_W; g++) begin : g_edge
    assign fell[g] = state_ff.primed & state_ff.cond_prev[g] & ~state_ff.cond[g];
    assign rose[g] = state_ff.primed & ~state_ff.cond_prev[g] & state_ff.cond[g];
    assign passed[g] = (fell[g] & state_ff.fall_mask[g]) | (rose[g] & state_ff.rise_mask[g]);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.cond = live_word;
    nxt_state.cond_prev = state_ff.cond;
    nxt_state.primed = 1'b1;
    nxt_state.rvalid = 1'b0;
    if (i_req.wr) begin
      unique case (i_req.sel)
        `FSE_SEL_FALL: nxt_state.fall_mask = i_req.wdata & `FSE_USED_MASK;
        `FSE_SEL_RISE: nxt_state.rise_mask = i_req.wdata & `FSE_USED_MASK;
        default: nxt_state.fall_mask = state_ff.fall_mask;
      endcase
    end
    if (i_req.rd) begin
      nxt_state.rvalid = 1'b1;
      unique case (i_req.sel)
        `FSE_SEL_COND: nxt_state.rdata = state_ff.cond;
        `FSE_SEL_FALL: nxt_state.rdata = state_ff.fall_mask;
        `FSE_SEL_RISE: nxt_state.rdata = state_ff.rise_mask;
        `FSE_SEL_EVENT: nxt_state.rdata = state_ff.event_word;
      endcase
    end
    // Clear on read, then new edges win over the clear
    if (i_req.rd && i_req.sel == `FSE_SEL_EVENT) begin
      nxt_state.event_word = passed;
    end else begin
      nxt_state.event_word = state_ff.event_word | passed;
    end
    nxt_state.summary = i_summary_en && (nxt_state.event_word != '0);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= '0;
      state_ff.fall_mask <= `FSE_MASK_RST;
      state_ff.rise_mask <= `FSE_MASK_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;
  assign o_rvalid = state_ff.rvalid;
  assign o_cond = state_ff.cond;
  assign o_event = state_ff.event_word;
  assign o_fault_summary_bit = state_ff.summary;

endmodule : fse_status_filter

// ### verification/fse_status_filter_sva.sv
/* Port checker of the fault status edge filter.
   Assumes one clock domain and synchronous reset. */
`timescale 1ns/1ps
`include "fse_regs.svh"
module fse_status_filter_sva (
  input wire logic i_clock, // Clock
  input wire logic i_srst, // Reset
  input wire fse_pkg::fse_flags_s i_flags, // Flags
  input wire fse_pkg::fse_req_s i_req, // Command
  input wire logic i_summary_en, // Enable
  input wire logic [15:0] o_rdata, // Read data
  input wire logic o_rvalid, // Read valid
  input wire logic [15:0] o_cond, // Condition
  input wire logic [15:0] o_event, // Events
  input wire logic o_fault_summary_bit // Summary
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic rd_ev;
  assign rd_ev = i_req.rd && (i_req.sel == `FSE_SEL_EVENT);
  property p_cond; !$past(i_srst) |-> o_cond == {6'h00, $past(i_flags)}; endproperty
  a_cond: assert property (p_cond) else $error("cond mismatch");
  property p_top; o_cond[15:10] == 6'h00; endproperty
  a_top: assert property (p_top) else $error("cond top bits set");
  property p_new; (o_event & ~$past(o_event) & ~($past(o_cond, 2) ^ $past(o_cond))) == 16'h0000; endproperty
  a_new: assert property (p_new) else $error("event without edge");
  property p_hold; !$past(i_srst) && !$past(rd_ev) |-> ($past(o_event) & ~o_event) == 16'h0000; endproperty
  a_hold: assert property (p_hold) else $error("event bit lost");
  property p_clr; rd_ev |=> o_rvalid && o_rdata == $past(o_event); endproperty
  a_clr: assert property (p_clr) else $error("event read wrong");
  property p_rv; !$past(i_srst) |-> o_rvalid == $past(i_req.rd); endproperty
  a_rv: assert property (p_rv) else $error("rvalid timing");
  property p_sum; !$past(i_srst) |-> o_fault_summary_bit == ($past(i_summary_en) && o_event != 16'h0000); endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_msk; i_req.rd && i_req.sel inside {`FSE_SEL_FALL, `FSE_SEL_RISE} |=> o_rdata[15:10] == 6'h00; endproperty
  a_msk: assert property (p_msk) else $error("mask top bits");
  c_rd: cover property (rd_ev);
  c_sum: cover property ($rose(o_fault_summary_bit));
  c_ev: cover property (o_event != 16'h0000);
endmodule : fse_status_filter_sva
bind fse_status_filter fse_status_filter_sva u_sva (.*);

// ### verification/fse_status_filter_tb.sv
/* Testbench of the fault status edge filter.
   Drives the ports directly; checker bound alongside. */
`timescale 1ns/1ps
`include "fse_regs.svh"
module fse_status_filter_tb;
  import fse_pkg::*;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  fse_flags_s i_flags = '0;
  fse_req_s i_req = '0;
  logic i_summary_en = 1'b1;
  logic [15:0] o_rdata, o_cond, o_event;
  logic o_rvalid, o_fault_summary_bit;
  int err_count = 0;
  int checked = 0;
  fse_status_filter DUT (.*);
  initial forever #4 i_clock = ~i_clock;
  task automatic cmp(input string n, input logic [16:0] g, input logic [16:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] d);
    @(posedge i_clock) i_req <= {w, ~w, s, d};
    @(posedge i_clock) i_req <= '0;
    #1;
  endtask : acc
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    acc(1'b0, s, 16'h0000);
    cmp("rdata", {o_rvalid, o_rdata}, {1'b1, e});
  endtask : rd
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (600) @(posedge i_clock);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(`FSE_SEL_FALL, 16'h0000);
    rd(`FSE_SEL_RISE, 16'h0000);
    acc(1'b1, `FSE_SEL_FALL, 16'hfc02);
    acc(1'b1, `FSE_SEL_RISE, 16'h0201);
    acc(1'b1, `FSE_SEL_COND, 16'h00ff);
    rd(`FSE_SEL_FALL, 16'h0002);
    rd(`FSE_SEL_RISE, 16'h0201);
    rd(`FSE_SEL_COND, 16'h0000);
    @(posedge i_clock) i_flags <= 10'h3ff;
    repeat (3) @(posedge i_clock);
    #1 cmp("event", o_event, 16'h0201);
    cmp("summary", o_fault_summary_bit, 1'b1);
    rd(`FSE_SEL_COND, 16'h03ff);
    rd(`FSE_SEL_EVENT, 16'h0201);
    cmp("cleared", {o_fault_summary_bit, o_event}, 17'h00000);
    @(posedge i_clock) i_flags <= 10'h000;
    repeat (3) @(posedge i_clock);
    rd(`FSE_SEL_EVENT, 16'h0002);
    @(posedge i_clock) begin
      i_summary_en <= 1'b0;
      i_flags <= 10'h004;
    end
    repeat (3) @(posedge i_clock);
    rd(`FSE_SEL_COND, 16'h0004);
    @(posedge i_clock) i_flags <= 10'h001;
    repeat (3) @(posedge i_clock);
    #1 cmp("event_nosum", {o_fault_summary_bit, o_event}, 17'h00001);
    end_sim();
  end
endmodule : fse_status_filter_tb
